/* core/dcc_map.vh */
`ifndef DCC_MAP_VH
`define DCC_MAP_VH

// Register word index inside a channel window (byte address = 4 * index)
`define DCC_RG_CTRL        4'h0
`define DCC_RG_PARAM       4'h1
`define DCC_RG_SRC         4'h2
`define DCC_RG_DST         4'h3
`define DCC_RG_ECNT        4'h4
`define DCC_RG_FCNT        4'h5
`define DCC_RG_EIDX        4'h6
`define DCC_RG_FIDX        4'h7
`define DCC_RG_STAT        4'h8
`define DCC_RG_WSRC        4'h9
`define DCC_RG_WDST        4'hA
`define DCC_RG_WCNT        4'hB
`define DCC_RG_LAST        4'hB
// Channel windows are 64 bytes apart; window 6 holds the global register
`define DCC_NUM_CH         6
`define DCC_GLOBAL_WIN     3'h6
`define DCC_RG_GLOBAL      4'h0

// Channel control register fields
`define DCC_CTL_DMODE_HI   15
`define DCC_CTL_DMODE_LO   14
`define DCC_CTL_SMODE_HI   13
`define DCC_CTL_SMODE_LO   12
`define DCC_CTL_DONE       11
`define DCC_CTL_RSVD       10
`define DCC_CTL_REPEAT     9
`define DCC_CTL_AUTO       8
`define DCC_CTL_EN         7
`define DCC_CTL_CHANNEL_PRIORITY_LEVEL       6
`define DCC_CTL_FRAME      5
`define DCC_CTL_SYNC_HI    4
`define DCC_CTL_SYNC_LO    0
`define DCC_CTL_RESET      16'h0000
`define DCC_CTL_WMASK      16'hFBFF

// Parameter register fields
`define DCC_PAR_SIZE_HI    1
`define DCC_PAR_SIZE_LO    0
`define DCC_PAR_SRC_RAM    2
`define DCC_PAR_DST_RAM    3
`define DCC_PAR_RESET      4'h0

// Global register fields
`define DCC_GBL_HPRIO      0
`define DCC_GBL_EXCL       1
`define DCC_GBL_RESET      2'h0

// Address update modes
`define DCC_AM_CONST       2'h0
`define DCC_AM_POSTINC     2'h1
`define DCC_AM_SINGLE      2'h2
`define DCC_AM_DOUBLE      2'h3

// Element sizes
`define DCC_SZ_8           2'h0
`define DCC_SZ_16          2'h1
`define DCC_SZ_32          2'h2
`define DCC_STEP_8         16'h0001
`define DCC_STEP_16        16'h0002
`define DCC_STEP_32        16'h0004

`define DCC_SYNC_NONE      5'h00

`endif

/* core/dcc_addr_step.v */
`timescale 1ns/10ps
`default_nettype none
`include "dcc_map.vh"

module dcc_addr_step (
	input  wire [1:0]  mode,
	input  wire [1:0]  size,
	input  wire [15:0] addr,
	input  wire [15:0] elem_idx,
	input  wire [15:0] frame_idx,
	input  wire        last_elem,
	output reg  [15:0] next_addr
);

	reg [15:0] step;

	always @* begin
		case (size)
			`DCC_SZ_8:  step = `DCC_STEP_8;  // [R3]
			`DCC_SZ_16: step = `DCC_STEP_16; // [R3]
			default:    step = `DCC_STEP_32; // [R3]
		endcase
	end

	// Indices wrap modulo 2^16, so negative indices work as two's complement
	always @* begin
		case (mode)
			`DCC_AM_CONST:   next_addr = addr;
			`DCC_AM_POSTINC: next_addr = addr + step;     // [R3]
			`DCC_AM_SINGLE:  next_addr = addr + elem_idx; // [R4]
			`DCC_AM_DOUBLE: begin
				if (last_elem) begin
					next_addr = addr + frame_idx; // [R5]
				end else begin
					next_addr = addr + elem_idx;  // [R5]
				end
			end
			default:         next_addr = addr;
		endcase
	end

endmodule // dcc_addr_step

`default_nettype wire

/* core/dcc_channel_control.v */
// What this block does
// [R1] Destination mode 00 const, 01 post-increment, 10 single, 11 double index.
// [R2] Source address has its own mode field with the same four encodings.
// [R3] Post-increment adds element size: 1, 2 or 4 bytes.
// [R4] Single index adds the element index after every element.
// [R5] Double index adds element index inside frame, frame index after last.
// [R6] On auto reload, configuration set is copied into working set.
// [R7] Reload needs setup-done flag unless repeat bit is set.
// [R8] Software clears repeat, clears setup-done, programs, then sets setup-done.
// [R9] Software always writes zero to the reserved control bit.
// [R10] Without auto reload the channel stops at the end of the block.
// [R11] With auto reload a new block starts when the current one completes.
// [R12] Without auto reload, hardware clears enable when a block completes.
// [R13] Clearing enable aborts the active transfer; disabled channels get no service.
// [R14] Hardware clear of enable beats a simultaneous software write.
// [R15] An enabled channel is served at its next free slot.
// [R16] Six fixed-position channels, high priority served before low.
// [R17] Element trigger mode moves one element per trigger event.
// [R18] A five-bit field selects the trigger event of each channel.
// [R19] Host priority bit orders the host port; ignored at RAM under exclusivity.
// [R20] Frame trigger mode moves a whole frame per trigger event.
// [R21] Trigger select zero means no wait: run once enabled.
// [R22] Enabling an idle channel loads its working set from configuration.
`timescale 1ns/10ps
`default_nettype none
`include "dcc_map.vh"

module dcc_channel_control (
	input  wire        clock,
	input  wire        rst_b,
	input  wire        clk_en,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [31:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output wire        xfer_valid,
	input  wire        xfer_ready,
	output reg  [2:0]  xfer_chan,
	output reg  [15:0] xfer_src_addr,
	output reg  [15:0] xfer_dst_addr,
	output reg  [1:0]  xfer_size,
	output reg         xfer_src_ram,
	output reg         xfer_dst_ram,
	input  wire [31:0] sync_evt,
	input  wire        host_req,
	output reg         host_grant
);

	localparam ST_IDLE = 1'b0;
	localparam ST_XFER = 1'b1;

	// Configuration set
	reg [15:0] ctl_ff   [0:5];
	reg [3:0]  par_ff   [0:5];
	reg [15:0] csrc_ff  [0:5];
	reg [15:0] cdst_ff  [0:5];
	reg [15:0] cecnt_ff [0:5];
	reg [15:0] cfcnt_ff [0:5];
	reg [15:0] ceidx_ff [0:5];
	reg [15:0] cfidx_ff [0:5];
	// Working set
	reg [15:0] wsrc_ff  [0:5];
	reg [15:0] wdst_ff  [0:5];
	reg [15:0] wecnt_ff [0:5];
	reg [15:0] wfcnt_ff [0:5];
	reg [15:0] weidx_ff [0:5];
	reg [15:0] wfidx_ff [0:5];
	reg [5:0]  act_ff;
	reg [5:0]  wait_ff;
	reg [5:0]  arm_ff;
	reg [1:0]  gbl_ff;
	reg        st_ff;
	reg [2:0]  cur_ff;

	// One loop index per process, so no variable has two driving processes
	integer i;
	integer c;
	integer p;

	function [15:0] dcc_merge;
		input [15:0] old;
		input [15:0] nw;
		input [1:0]  sel;
		begin
			dcc_merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
		end
	endfunction

	// Bus decode
	wire [2:0] bus_ch    = wb_adr_i[8:6];
	wire [3:0] bus_rg    = wb_adr_i[5:2];
	wire       bus_hi_ok = (wb_adr_i[31:9] == 23'h00_0000);
	wire       bus_is_ch = bus_hi_ok && (bus_ch < `DCC_NUM_CH) && (bus_rg <= `DCC_RG_LAST);
	wire       bus_is_gb = bus_hi_ok && (bus_ch == `DCC_GLOBAL_WIN) && (bus_rg == `DCC_RG_GLOBAL);
	wire       bus_req   = wb_cyc_i && wb_stb_i;
	// Write lands on the edge where the master samples ack
	wire       bus_wr    = bus_req && wb_we_i && wb_ack_o;
	wire [15:0] wr_ctl   = dcc_merge(ctl_ff[bus_ch], wb_dat_i[15:0], wb_sel_i[1:0])
		& `DCC_CTL_WMASK;

	// Per-channel event decode
	reg  [5:0] sw_ctl_wr;
	reg  [5:0] en_rise;
	reg  [5:0] en_fall;
	reg  [5:0] fin;
	reg  [5:0] may_reload;
	reg  [5:0] reload;
	reg  [5:0] load;
	reg  [5:0] hw_clr;
	reg  [5:0] evt;
	reg  [5:0] elig;
	reg  [5:0] uses_ram;

	wire       done      = (st_ff == ST_XFER) && xfer_ready && ctl_ff[cur_ff][`DCC_CTL_EN];
	wire       abort     = (st_ff == ST_XFER) && !ctl_ff[cur_ff][`DCC_CTL_EN];
	wire       last_elem = (wecnt_ff[cur_ff] == 16'h0001);
	wire       blk_end   = last_elem && (wfcnt_ff[cur_ff] == 16'h0001);

	always @* begin
		for (c = 0; c < `DCC_NUM_CH; c = c + 1) begin
			sw_ctl_wr[c]  = bus_wr && bus_is_ch && (bus_ch == c) && (bus_rg == `DCC_RG_CTRL);
			en_rise[c]    = sw_ctl_wr[c] && wr_ctl[`DCC_CTL_EN] && !act_ff[c]; // [R22]
			en_fall[c]    = sw_ctl_wr[c] && !wr_ctl[`DCC_CTL_EN];
			fin[c]        = done && (cur_ff == c) && blk_end;
			may_reload[c] = ctl_ff[c][`DCC_CTL_AUTO]
				&& (ctl_ff[c][`DCC_CTL_REPEAT] || ctl_ff[c][`DCC_CTL_DONE]); // [R7]
			reload[c]     = may_reload[c] && (fin[c]
				|| (wait_ff[c] && ctl_ff[c][`DCC_CTL_EN] && !sw_ctl_wr[c])); // [R6] [R11]
			load[c]       = en_rise[c] || reload[c];
			// Auto reload off at block end, or dropped while waiting: stop
			hw_clr[c]     = (fin[c] || wait_ff[c]) && !ctl_ff[c][`DCC_CTL_AUTO]; // [R10] [R12]
			evt[c]        = (ctl_ff[c][`DCC_CTL_SYNC_HI:`DCC_CTL_SYNC_LO] != `DCC_SYNC_NONE)
				&& sync_evt[ctl_ff[c][`DCC_CTL_SYNC_HI:`DCC_CTL_SYNC_LO]]; // [R18]
			uses_ram[c]   = par_ff[c][`DCC_PAR_SRC_RAM] || par_ff[c][`DCC_PAR_DST_RAM];
			elig[c]       = ctl_ff[c][`DCC_CTL_EN] && act_ff[c] && !wait_ff[c] // [R13] [R15]
				&& ((ctl_ff[c][`DCC_CTL_SYNC_HI:`DCC_CTL_SYNC_LO] == `DCC_SYNC_NONE) // [R21]
				|| arm_ff[c]) // [R17] [R20]
				&& !(gbl_ff[`DCC_GBL_EXCL] && uses_ram[c]); // [R19]
		end
	end

	// Fixed position chain: lowest index wins inside a priority level
	reg [2:0] pick;
	reg       any_hi;
	reg       any;

	always @* begin
		pick   = 3'h0;
		any_hi = 1'b0;
		any    = |elig;
		for (p = `DCC_NUM_CH - 1; p >= 0; p = p - 1) begin
			if (elig[p] && ctl_ff[p][`DCC_CTL_CHANNEL_PRIORITY_LEVEL]) begin
				any_hi = 1'b1;
			end
		end
		for (p = `DCC_NUM_CH - 1; p >= 0; p = p - 1) begin
			if (elig[p] && (ctl_ff[p][`DCC_CTL_CHANNEL_PRIORITY_LEVEL] == any_hi)) begin
				pick = p[2:0]; // [R16]
			end
		end
	end

	// Host wins the slot when it is high priority or no channel is ready
	wire host_win = host_req && (gbl_ff[`DCC_GBL_HPRIO] || !any); // [R19]

	// Address steppers for the channel in service
	wire [15:0] nxt_src;
	wire [15:0] nxt_dst;

	dcc_addr_step u_src_step (
		.mode      (ctl_ff[cur_ff][`DCC_CTL_SMODE_HI:`DCC_CTL_SMODE_LO]), // [R2]
		.size      (par_ff[cur_ff][`DCC_PAR_SIZE_HI:`DCC_PAR_SIZE_LO]),
		.addr      (wsrc_ff[cur_ff]),
		.elem_idx  (weidx_ff[cur_ff]),
		.frame_idx (wfidx_ff[cur_ff]),
		.last_elem (last_elem),
		.next_addr (nxt_src)
	);

	dcc_addr_step u_dst_step (
		.mode      (ctl_ff[cur_ff][`DCC_CTL_DMODE_HI:`DCC_CTL_DMODE_LO]), // [R1]
		.size      (par_ff[cur_ff][`DCC_PAR_SIZE_HI:`DCC_PAR_SIZE_LO]),
		.addr      (wdst_ff[cur_ff]),
		.elem_idx  (weidx_ff[cur_ff]),
		.frame_idx (wfidx_ff[cur_ff]),
		.last_elem (last_elem),
		.next_addr (nxt_dst)
	);

	// Channel register file and working state
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (i = 0; i < `DCC_NUM_CH; i = i + 1) begin
				ctl_ff[i]   <= `DCC_CTL_RESET;
				par_ff[i]   <= `DCC_PAR_RESET;
				csrc_ff[i]  <= 16'h0000;
				cdst_ff[i]  <= 16'h0000;
				cecnt_ff[i] <= 16'h0000;
				cfcnt_ff[i] <= 16'h0000;
				ceidx_ff[i] <= 16'h0000;
				cfidx_ff[i] <= 16'h0000;
				wsrc_ff[i]  <= 16'h0000;
				wdst_ff[i]  <= 16'h0000;
				wecnt_ff[i] <= 16'h0000;
				wfcnt_ff[i] <= 16'h0000;
				weidx_ff[i] <= 16'h0000;
				wfidx_ff[i] <= 16'h0000;
			end
			act_ff  <= 6'h00;
			wait_ff <= 6'h00;
			arm_ff  <= 6'h00;
			gbl_ff  <= `DCC_GBL_RESET;
		end else if (clk_en) begin
			if (bus_wr && bus_is_gb) begin
				gbl_ff <= wb_dat_i[1:0];
			end
			for (i = 0; i < `DCC_NUM_CH; i = i + 1) begin
				if (bus_wr && bus_is_ch && (bus_ch == i)) begin
					case (bus_rg)
						`DCC_RG_CTRL:  ctl_ff[i]   <= wr_ctl;
						`DCC_RG_PARAM: par_ff[i]   <= wb_dat_i[3:0];
						`DCC_RG_SRC:   csrc_ff[i]  <= dcc_merge(csrc_ff[i], wb_dat_i[15:0], wb_sel_i[1:0]);
						`DCC_RG_DST:   cdst_ff[i]  <= dcc_merge(cdst_ff[i], wb_dat_i[15:0], wb_sel_i[1:0]);
						`DCC_RG_ECNT:  cecnt_ff[i] <= dcc_merge(cecnt_ff[i], wb_dat_i[15:0], wb_sel_i[1:0]);
						`DCC_RG_FCNT:  cfcnt_ff[i] <= dcc_merge(cfcnt_ff[i], wb_dat_i[15:0], wb_sel_i[1:0]);
						`DCC_RG_EIDX:  ceidx_ff[i] <= dcc_merge(ceidx_ff[i], wb_dat_i[15:0], wb_sel_i[1:0]);
						`DCC_RG_FIDX:  cfidx_ff[i] <= dcc_merge(cfidx_ff[i], wb_dat_i[15:0], wb_sel_i[1:0]);
						default: ;
					endcase
				end
				// Element bookkeeping for the channel in service
				if (done && (cur_ff == i)) begin
					wsrc_ff[i] <= nxt_src;
					wdst_ff[i] <= nxt_dst;
					if (last_elem) begin
						wecnt_ff[i] <= cecnt_ff[i];
						wfcnt_ff[i] <= wfcnt_ff[i] - 16'h0001;
					end else begin
						wecnt_ff[i] <= wecnt_ff[i] - 16'h0001;
					end
				end
				if (fin[i]) begin
					act_ff[i]  <= 1'b0;
					wait_ff[i] <= ctl_ff[i][`DCC_CTL_AUTO]; // [R7]
				end
				if (hw_clr[i]) begin
					wait_ff[i] <= 1'b0;
				end
				if (load[i]) begin
					wsrc_ff[i]  <= csrc_ff[i]; // [R6] [R22]
					wdst_ff[i]  <= cdst_ff[i];
					wecnt_ff[i] <= cecnt_ff[i];
					wfcnt_ff[i] <= cfcnt_ff[i];
					weidx_ff[i] <= ceidx_ff[i];
					wfidx_ff[i] <= cfidx_ff[i];
					act_ff[i]   <= 1'b1;
					wait_ff[i]  <= 1'b0;
				end
				if (en_fall[i]) begin
					act_ff[i]  <= 1'b0; // [R13]
					wait_ff[i] <= 1'b0;
				end
				// Hardware clear is applied last so it overrides a software write
				if (hw_clr[i]) begin
					ctl_ff[i][`DCC_CTL_EN] <= 1'b0; // [R12] [R14]
				end
				// A trigger arriving with the clear still arms the channel
				if (done && (cur_ff == i)
					&& (!ctl_ff[i][`DCC_CTL_FRAME] || last_elem)) begin
					arm_ff[i] <= evt[i]; // [R17] [R20]
				end else if (evt[i]) begin
					arm_ff[i] <= 1'b1;
				end
			end
		end
	end

	assign xfer_valid = (st_ff == ST_XFER) && ctl_ff[cur_ff][`DCC_CTL_EN]; // [R13]

	// Service engine: one element per slot, re-arbitrated each element
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_ff         <= ST_IDLE;
			cur_ff        <= 3'h0;
			host_grant    <= 1'b0;
			xfer_chan     <= 3'h0;
			xfer_src_addr <= 16'h0000;
			xfer_dst_addr <= 16'h0000;
			xfer_size     <= 2'h0;
			xfer_src_ram  <= 1'b0;
			xfer_dst_ram  <= 1'b0;
		end else if (clk_en) begin
			case (st_ff)
				ST_IDLE: begin
					host_grant <= host_win;
					if (!host_win && any) begin
						st_ff         <= ST_XFER; // [R15]
						cur_ff        <= pick;
						xfer_chan     <= pick;
						xfer_src_addr <= wsrc_ff[pick];
						xfer_dst_addr <= wdst_ff[pick];
						xfer_size     <= par_ff[pick][`DCC_PAR_SIZE_HI:`DCC_PAR_SIZE_LO];
						xfer_src_ram  <= par_ff[pick][`DCC_PAR_SRC_RAM];
						xfer_dst_ram  <= par_ff[pick][`DCC_PAR_DST_RAM];
					end
				end
				ST_XFER: begin
					host_grant <= 1'b0;
					if (done || abort) begin
						st_ff <= ST_IDLE; // [R13]
					end
				end
				default: begin
					st_ff      <= ST_IDLE;
					host_grant <= 1'b0;
				end
			endcase
		end
	end

	// Wishbone slave: ack one cycle after the request, dropped the next cycle
	reg [31:0] rd_data;

	always @* begin
		rd_data = 32'h0000_0000;
		if (bus_is_gb) begin
			rd_data = {30'h0000_0000, gbl_ff};
		end else if (bus_is_ch) begin
			case (bus_rg)
				`DCC_RG_CTRL:  rd_data = {16'h0000, ctl_ff[bus_ch]};
				`DCC_RG_PARAM: rd_data = {28'h000_0000, par_ff[bus_ch]};
				`DCC_RG_SRC:   rd_data = {16'h0000, csrc_ff[bus_ch]};
				`DCC_RG_DST:   rd_data = {16'h0000, cdst_ff[bus_ch]};
				`DCC_RG_ECNT:  rd_data = {16'h0000, cecnt_ff[bus_ch]};
				`DCC_RG_FCNT:  rd_data = {16'h0000, cfcnt_ff[bus_ch]};
				`DCC_RG_EIDX:  rd_data = {16'h0000, ceidx_ff[bus_ch]};
				`DCC_RG_FIDX:  rd_data = {16'h0000, cfidx_ff[bus_ch]};
				`DCC_RG_STAT:  rd_data = {29'h0000_0000, arm_ff[bus_ch], wait_ff[bus_ch],
					act_ff[bus_ch]};
				`DCC_RG_WSRC:  rd_data = {16'h0000, wsrc_ff[bus_ch]};
				`DCC_RG_WDST:  rd_data = {16'h0000, wdst_ff[bus_ch]};
				`DCC_RG_WCNT:  rd_data = {wfcnt_ff[bus_ch], wecnt_ff[bus_ch]};
				default:       rd_data = 32'h0000_0000;
			endcase
		end
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (clk_en) begin
			wb_ack_o <= bus_req && !wb_ack_o;
			if (bus_req && !wb_ack_o) begin
				wb_dat_o <= rd_data;
			end
		end
	end

endmodule // dcc_channel_control

`default_nettype wire

/* dv/dcc_channel_control_props.sv */
`timescale 1ns/10ps
`default_nettype none
module dcc_channel_control_props (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        clk_en,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic        wb_ack_o,
	input wire logic        xfer_valid,
	input wire logic        xfer_ready,
	input wire logic [2:0]  xfer_chan,
	input wire logic [15:0] xfer_src_addr,
	input wire logic [15:0] xfer_dst_addr,
	input wire logic [1:0]  xfer_size,
	input wire logic        host_req,
	input wire logic        host_grant
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
	// A write in flight may clear the enable, which legally aborts the element
	wire elem_wait = xfer_valid && !xfer_ready && clk_en && !(wb_cyc_i && wb_we_i);

	ack_next_cycle_a: assert property (bus_req |=> wb_ack_o)
		else $error("bus request not answered in the next cycle");
	ack_one_cycle_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
		else $error("bus ack held longer than one cycle");
	elem_holds_a: assert property (elem_wait |=> xfer_valid)
		else $error("element request dropped before acceptance");
	elem_stable_a: assert property (elem_wait |=> $stable(xfer_src_addr)
		&& $stable(xfer_dst_addr) && $stable(xfer_chan) && $stable(xfer_size))
		else $error("element payload changed while waiting");
	elem_gap_a: assert property (xfer_valid && xfer_ready && clk_en |=> !xfer_valid)
		else $error("no idle cycle after an accepted element");
	reset_quiet_a: assert property ($rose(rst_b) |-> !xfer_valid && !wb_ack_o && !host_grant)
		else $error("outputs active right after reset");
	grant_cause_a: assert property ($rose(host_grant) |-> $past(host_req))
		else $error("host grant without a host request");
	grant_holds_a: assert property (host_grant && host_req && clk_en |=> host_grant)
		else $error("host grant dropped while requested");
	freeze_all_a: assert property (!clk_en |=> $stable(wb_ack_o) && $stable(host_grant)
		&& $stable(xfer_valid))
		else $error("outputs moved while clock enable low");

	cover property (xfer_valid && xfer_ready);
	cover property (elem_wait);
	cover property ($rose(host_grant));
endmodule // dcc_channel_control_props

bind dcc_channel_control dcc_channel_control_props u_props (
	.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
	.xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_chan(xfer_chan),
	.xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr),
	.xfer_size(xfer_size), .host_req(host_req), .host_grant(host_grant)
);
`default_nettype wire

/* dv/dcc_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dcc_mem_model (
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       xfer_valid,
	input  wire logic [3:0] stall,
	output wire logic       xfer_ready
);
	logic [3:0] wait_ff;
	logic       ready_ff;
	assign xfer_ready = ready_ff;
	// Ready toggles while idle, the block has to ignore it then
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wait_ff <= 4'h0;
			ready_ff <= 1'h0;
		end else if (xfer_valid && !ready_ff) begin
			wait_ff <= wait_ff + 4'h1;
			ready_ff <= (wait_ff >= stall);
		end else begin
			wait_ff <= 4'h0;
			ready_ff <= !xfer_valid && !ready_ff;
		end
	end
endmodule // dcc_mem_model
`default_nettype wire

/* dv/dcc_channel_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dcc_map.vh"
module dcc_channel_control_test;
	logic        clock, rst_b, clk_en, cyc, stb, we, host_req;
	logic [3:0]  sel, stall;
	logic [31:0] adr, wdat, sync_evt, rd;
	logic [15:0] sq[$], dq[$], sa, da;
	logic [2:0]  cq[$];
	logic [3:0]  zq[$];
	logic [1:0]  md;
	integer      n_fail, tests_run, k, e;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, xfer_valid, xfer_ready, host_grant, xfer_src_ram, xfer_dst_ram;
	wire  [1:0]  xfer_size;
	wire  [2:0]  xfer_chan;
	wire  [15:0] xfer_src_addr, xfer_dst_addr;

	dcc_channel_control dut (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_chan(xfer_chan),
		.xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr),
		.xfer_size(xfer_size), .xfer_src_ram(xfer_src_ram), .xfer_dst_ram(xfer_dst_ram),
		.sync_evt(sync_evt), .host_req(host_req),
		.host_grant(host_grant));
	dcc_mem_model mem (.clock(clock), .rst_b(rst_b), .xfer_valid(xfer_valid),
		.stall(stall), .xfer_ready(xfer_ready));

	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		if (rst_b === 1'h1 && xfer_valid === 1'h1 && xfer_ready === 1'h1) begin
			sq.push_back(xfer_src_addr);
			dq.push_back(xfer_dst_addr);
			cq.push_back(xfer_chan);
			zq.push_back({xfer_dst_ram, xfer_src_ram, xfer_size});
		end
	end

	task stop_test;
		begin
			$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
			if (n_fail == 0 && tests_run > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			tests_run++;
			if (seen !== exp) begin
				n_fail++;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [15:0] d);
		int i;
		begin
			@(posedge clock);
			cyc <= 1'h1;
			stb <= 1'h1;
			we <= w;
			sel <= 4'h3;
			adr <= a;
			wdat <= {16'h0000, d};
			i = 0;
			do begin
				@(posedge clock);
				i++;
			end while (wb_ack_o !== 1'h1 && i < 20);
			rd = wb_dat_o;
			cyc <= 1'h0;
			stb <= 1'h0;
			if (wb_ack_o !== 1'h1) begin
				n_fail++;
				$display("[FAIL] %0t bus not answered", $time);
				stop_test();
			end
		end
	endtask
	task wr(input logic [31:0] a, input logic [15:0] d);
		bus(1'h1, a, d);
	endtask
	task rc(input logic [31:0] a, input logic [15:0] exp);
		begin
			bus(1'h0, a, 16'h0000);
			chk(rd, {16'h0000, exp});
		end
	endtask
	function automatic logic [31:0] ra(input int ch, input int r);
		return 32'(ch * 64 + r * 4);
	endfunction
	task prog(input int ch, input logic [15:0] s, input logic [15:0] ec,
			input logic [15:0] fc, input logic [15:0] pr);
		logic [15:0] v[7];
		begin
			v = '{pr, s, 16'h0200, ec, fc, 16'h0010, 16'h0040};
			for (int r = 1; r < 8; r++)
				wr(ra(ch, r), v[r - 1]);
		end
	endtask
	task clr;
		begin
			sq.delete();
			dq.delete();
			cq.delete();
			zq.delete();
		end
	endtask
	task wait_n(input int n);
		int i;
		begin
			for (i = 0; i < 400 && sq.size() < n; i++)
				@(posedge clock);
			if (sq.size() < n) begin
				n_fail++;
				$display("[FAIL] %0t elements missing", $time);
				stop_test();
			end
		end
	endtask
	task pulse(input int b);
		begin
			@(posedge clock);
			sync_evt[b] <= 1'h1;
			@(posedge clock);
			sync_evt <= 32'h0000_0000;
			repeat (10) @(posedge clock);
		end
	endtask
	function automatic logic [15:0] nxt(input logic [1:0] m, input logic [1:0] z,
			input logic [15:0] a, input logic l);
		case (m)
			`DCC_AM_CONST: return a;
			`DCC_AM_POSTINC: return a + (16'h0001 << z);
			`DCC_AM_SINGLE: return a + 16'h0010;
			default: return a + (l ? 16'h0040 : 16'h0010);
		endcase
	endfunction

	initial begin
		n_fail = 0;
		tests_run = 0;
		{rst_b, cyc, stb, we, host_req} = 5'h00;
		clk_en = 1'h1;
		sel = 4'h3;
		stall = 4'h0;
		adr = 32'h0000_0000;
		wdat = 32'h0000_0000;
		sync_evt = 32'h0000_0000;
		repeat (20) @(posedge clock);
		rst_b <= 1'h1;
		rc(ra(3, 0), 16'h0000);
		rc(32'h0000_01C0, 16'h0000);
		// Two frames of two elements; source and destination use opposite modes
		for (k = 0; k < 4; k++) begin
			md = k[1:0];
			clr();
			prog(0, 16'h0100, 16'h0002, 16'h0002, {14'h0000, 2'(k % 3)});
			wr(ra(0, 0), {md, ~md, 12'h080});
			wait_n(4);
			repeat (10) @(posedge clock);
			chk(32'(sq.size()), 32'h0000_0004);
			sa = 16'h0100;
			da = 16'h0200;
			for (e = 0; e < 4; e++) begin
				chk({16'h0000, sq[e]}, {16'h0000, sa});
				chk({16'h0000, dq[e]}, {16'h0000, da});
				chk({28'h000_0000, zq[e]}, {30'h0000_0000, 2'(k % 3)});
				sa = nxt(~md, 2'(k % 3), sa, e[0]);
				da = nxt(md, 2'(k % 3), da, e[0]);
			end
			rc(ra(0, 0), {md, ~md, 12'h000});
		end
		clr();
		prog(0, 16'h0100, 16'h0001, 16'h0001, 16'h0000);
		wr(ra(0, 0), 16'h0380);
		wait_n(2);
		chk({16'h0000, sq[1]}, 32'h0000_0100);
		wr(ra(0, 2), 16'h0300);
		clr();
		wait_n(3);
		chk({16'h0000, sq[2]}, 32'h0000_0300);
		stall <= 4'h8;
		wr(ra(0, 0), 16'h0300);
		repeat (2) @(posedge clock);
		clr();
		repeat (20) @(posedge clock);
		chk(32'(sq.size()), 32'h0000_0000);
		stall <= 4'h0;
		// Reload waits for the setup flag when repeat is off
		wr(ra(0, 0), 16'h0180);
		wait_n(1);
		wr(ra(0, 2), 16'h0180);
		repeat (10) @(posedge clock);
		chk(32'(sq.size()), 32'h0000_0001);
		bus(1'h0, ra(0, 8), 16'h0000);
		chk(rd & 32'h0000_0002, 32'h0000_0002);
		wr(ra(0, 0), 16'h0980);
		wait_n(2);
		chk({16'h0000, sq[1]}, 32'h0000_0180);
		wr(ra(0, 0), 16'h0000);
		prog(0, 16'h0100, 16'h0003, 16'h0002, 16'h0000);
		clr();
		wr(ra(0, 0), 16'h0085);
		repeat (10) @(posedge clock);
		chk(32'(sq.size()), 32'h0000_0000);
		pulse(5);
		chk(32'(sq.size()), 32'h0000_0001);
		pulse(4);
		pulse(5);
		chk(32'(sq.size()), 32'h0000_0002);
		wr(ra(0, 0), 16'h0000);
		clr();
		wr(ra(0, 0), 16'h00A5);
		pulse(5);
		chk(32'(sq.size()), 32'h0000_0003);
		wr(ra(0, 0), 16'h0000);
		for (k = 0; k < 2; k++) begin
			prog(1, 16'h0100, 16'h0001, 16'h0001, 16'h0000);
			prog(2, 16'h0100, 16'h0001, 16'h0001, 16'h0000);
			wr(ra(1, 0), 16'h0083);
			wr(ra(2, 0), {9'h001, k[0], 6'h03});
			clr();
			pulse(3);
			wait_n(2);
			chk({29'h0000_0000, cq[0]}, 32'(1 + k));
		end
		// Exclusive host access holds back a channel that uses a RAM port
		prog(0, 16'h0100, 16'h0001, 16'h0001, 16'h000C);
		wr(32'h0000_0180, 16'h0002);
		clr();
		wr(ra(0, 0), 16'h0080);
		repeat (10) @(posedge clock);
		chk(32'(sq.size()), 32'h0000_0000);
		wr(32'h0000_0180, 16'h0000);
		wait_n(1);
		chk({28'h000_0000, zq[0]}, 32'h0000_000C);
		// A channel that is always ready keeps a low priority host out
		wr(ra(0, 0), 16'h0380);
		host_req <= 1'h1;
		repeat (20) @(posedge clock);
		chk({31'h0000_0000, host_grant}, 32'h0000_0000);
		wr(32'h0000_0180, 16'h0001);
		for (k = 0; k < 50 && host_grant !== 1'h1; k++)
			@(posedge clock);
		chk({31'h0000_0000, host_grant}, 32'h0000_0001);
		clk_en <= 1'h0;
		repeat (3) @(posedge clock);
		clk_en <= 1'h1;
		host_req <= 1'h0;
		repeat (5) @(posedge clock);
		stop_test();
	end
endmodule // dcc_channel_control_test
`default_nettype wire
